// ==== hdl/adc_window_pkg.sv ====
// Constants for the converter result formatter and window detector
// Notes on behaviour
// RL1: Right-justified: top two bits in high byte 1-0, low eight in low byte.
// RL2: Right-justified high byte bits 7-2 copy bit 1 if differential, else zeros.
// RL3: Left-justified: top eight bits in high byte, lowest two in low byte 7-6.
// RL4: Single-ended codes unsigned, 0x0000-0x03FF right or 0x0000-0xFFC0 left.
// RL5: Differential codes two's complement, 0xFE00-0x01FF right or 0x8000-0x7FC0 left.
// RL6: Every completed conversion is compared to both limits without software help.
// RL7: Comparison is evaluated at end of conversion and sets the flag then.
// RL8: Window-match flag is readable so software may poll it.
// RL9: Limit words are high byte concatenated over low byte.
// RL10: Less-than above greater-than: match when strictly between both limits.
// RL11: Less-than below greater-than: match when below less-than or above greater-than.
// RL12: Differential readings compare data and limits as signed 16-bit values.
// RL13: Left-justified data compares directly with limits in the same scale.
// RL14: Flag stays set until software clears it; hardware never clears it.
// RL15: One left-justify select bit: clear right-justified, set left-justified.
// RL16: A false comparison leaves the flag unchanged.
// RL17: Equal limits use the outside-window rule.
package adc_window_pkg;
   localparam int RESULT_W = 10;
   localparam int WORD_W = 16;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'h_be;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'h_bf;
   localparam logic [7:0] ADDR_GT_LOW = 8'h_c4;
   localparam logic [7:0] ADDR_GT_HIGH = 8'h_c5;
   localparam logic [7:0] ADDR_LT_LOW = 8'h_c6;
   localparam logic [7:0] ADDR_LT_HIGH = 8'h_c7;
   localparam logic [7:0] ADDR_CONTROL = 8'h_e8;
   localparam int CTRL_LJST_BIT = 0;
   localparam int CTRL_WMATCH_BIT = 1;
   localparam logic [7:0] GT_HIGH_RESET = 8'h_ff;
   localparam logic [7:0] GT_LOW_RESET = 8'h_ff;
   localparam logic [7:0] LT_HIGH_RESET = 8'h_00;
   localparam logic [7:0] LT_LOW_RESET = 8'h_00;
   localparam logic [15:0] WORD_RESET = 16'h_0000;
endpackage

// ==== hdl/window_compare.sv ====
// Window comparator for one formatted data word
`timescale 1ns/10ps
`default_nettype none
module window_compare (
   input wire logic [15:0] data_i,
   input wire logic [15:0] less_limit_i,
   input wire logic [15:0] greater_limit_i,
   input wire logic signed_i,
   output logic match_o
);
   // Flipping the sign bit turns a signed compare into an unsigned one
   wire [15:0] data_k = {data_i[15] ^ signed_i, data_i[14:0]}; // [RL12]
   wire [15:0] lt_k = {less_limit_i[15] ^ signed_i, less_limit_i[14:0]}; // [RL12]
   wire [15:0] gt_k = {greater_limit_i[15] ^ signed_i, greater_limit_i[14:0]}; // [RL12]
   wire below_lt = data_k < lt_k;
   wire above_gt = data_k > gt_k;
   wire inside_mode = lt_k > gt_k;
   assign match_o = inside_mode ? (below_lt & above_gt) // [RL10]
                                : (below_lt | above_gt); // [RL11] [RL17]
endmodule // window_compare
`default_nettype wire

// ==== hdl/adc_result_window.sv ====
// Result formatter, limit registers and window-match flag
`timescale 1ns/10ps
`default_nettype none
module adc_result_window #(
   parameter int RESULT_W = adc_window_pkg::RESULT_W
) (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic eoc_i,
   input wire logic [RESULT_W-1:0] result_i,
   input wire logic differential_i,
   input wire logic sfr_wr_i,
   input wire logic sfr_rd_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   output logic window_match_flag_o,
   output logic left_justify_select_o
);
   logic [7:0] result_high_byte_reg, result_low_byte_reg;
   logic [7:0] gt_high_reg, gt_low_reg, lt_high_reg, lt_low_reg;
   logic left_justify_select_reg, window_match_flag_reg, window_match_flag_next;
   logic [15:0] word_right, word_left, word_next;
   logic match;

   // Strobe and address come in as arguments so each named wire follows both
   function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] a);
      return wr && addr == a;
   endfunction

   // One named strobe per writable register keeps the register process short
   wire wr_ctrl = wr_hit(sfr_wr_i, sfr_addr_i, adc_window_pkg::ADDR_CONTROL);
   wire wr_gt_high = wr_hit(sfr_wr_i, sfr_addr_i, adc_window_pkg::ADDR_GT_HIGH);
   wire wr_gt_low = wr_hit(sfr_wr_i, sfr_addr_i, adc_window_pkg::ADDR_GT_LOW);
   wire wr_lt_high = wr_hit(sfr_wr_i, sfr_addr_i, adc_window_pkg::ADDR_LT_HIGH);
   wire wr_lt_low = wr_hit(sfr_wr_i, sfr_addr_i, adc_window_pkg::ADDR_LT_LOW);
   wire sign_fill = differential_i & result_i[RESULT_W-1];
   assign word_right = {{6{sign_fill}}, result_i}; // [RL1] [RL2] [RL4] [RL5]
   assign word_left = {result_i, 6'b00_0000}; // [RL3] [RL4] [RL5]
   assign word_next = left_justify_select_reg ? word_left : word_right; // [RL15]

   // The fresh word is compared, not the stored one, so the flag lands with the data
   window_compare cmp_u (
      .data_i(word_next), // [RL6] [RL13]
      .less_limit_i({lt_high_reg, lt_low_reg}), // [RL9]
      .greater_limit_i({gt_high_reg, gt_low_reg}), // [RL9]
      .signed_i(differential_i), // [RL12]
      .match_o(match)
   );

   // Set beats a software clear in the same cycle
   assign window_match_flag_next = (eoc_i && match) ? 1'b1 // [RL7]
      : (wr_ctrl ? sfr_wdata_i[adc_window_pkg::CTRL_WMATCH_BIT] & window_match_flag_reg // [RL14]
      : window_match_flag_reg); // [RL16]

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         result_high_byte_reg <= adc_window_pkg::WORD_RESET[15:8];
         result_low_byte_reg <= adc_window_pkg::WORD_RESET[7:0];
      end else if (eoc_i) begin
         result_high_byte_reg <= word_next[15:8];
         result_low_byte_reg <= word_next[7:0];
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gt_high_reg <= adc_window_pkg::GT_HIGH_RESET;
         gt_low_reg <= adc_window_pkg::GT_LOW_RESET;
         lt_high_reg <= adc_window_pkg::LT_HIGH_RESET;
         lt_low_reg <= adc_window_pkg::LT_LOW_RESET;
         left_justify_select_reg <= 1'b0;
         window_match_flag_reg <= 1'b0;
      end else begin
         window_match_flag_reg <= window_match_flag_next;
         if (wr_ctrl) begin
            left_justify_select_reg <= sfr_wdata_i[adc_window_pkg::CTRL_LJST_BIT]; // [RL15]
         end
         if (wr_gt_high) gt_high_reg <= sfr_wdata_i; // [RL9]
         if (wr_gt_low) gt_low_reg <= sfr_wdata_i; // [RL9]
         if (wr_lt_high) lt_high_reg <= sfr_wdata_i; // [RL9]
         if (wr_lt_low) lt_low_reg <= sfr_wdata_i; // [RL9]
      end
   end

   // Read data is combinational from registers; unmapped addresses read zero
   always_comb begin
      sfr_rdata_o = 8'h_00;
      if (sfr_rd_i) begin
         unique case (sfr_addr_i)
            adc_window_pkg::ADDR_RESULT_HIGH: sfr_rdata_o = result_high_byte_reg;
            adc_window_pkg::ADDR_RESULT_LOW: sfr_rdata_o = result_low_byte_reg;
            adc_window_pkg::ADDR_GT_HIGH: sfr_rdata_o = gt_high_reg;
            adc_window_pkg::ADDR_GT_LOW: sfr_rdata_o = gt_low_reg;
            adc_window_pkg::ADDR_LT_HIGH: sfr_rdata_o = lt_high_reg;
            adc_window_pkg::ADDR_LT_LOW: sfr_rdata_o = lt_low_reg;
            adc_window_pkg::ADDR_CONTROL: sfr_rdata_o = {6'b00_0000, window_match_flag_reg,
               left_justify_select_reg}; // [RL8]
            default: sfr_rdata_o = 8'h_00;
         endcase
      end
   end

   assign window_match_flag_o = window_match_flag_reg; // [RL8]
   assign left_justify_select_o = left_justify_select_reg;

   sequence eoc_hit_s;
      eoc_i && match;
   endsequence

   // Software writes a zero to the flag bit with no matching conversion alongside
   sequence soft_clear_s;
      wr_ctrl && !sfr_wdata_i[adc_window_pkg::CTRL_WMATCH_BIT] && !(eoc_i && match);
   endsequence

   // A matching conversion lands in the same cycle as any control register write
   sequence clash_s;
      eoc_i && match && wr_ctrl;
   endsequence

   sequence flag_up_s;
      window_match_flag_reg;
   endsequence

   flag_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL7]
      eoc_hit_s |=> window_match_flag_reg)
      else $error("window flag not set after matching conversion");
   flag_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL14]
      window_match_flag_reg && !wr_ctrl |=> window_match_flag_reg)
      else $error("window flag dropped without software clear");
   no_false_set_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL16]
      !window_match_flag_reg && !(eoc_i && match) |=> !window_match_flag_reg)
      else $error("window flag set without a match");
   low_pad_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL3]
      eoc_i && left_justify_select_reg |=> result_low_byte_reg[5:0] == 6'b00_0000
         && result_high_byte_reg == $past(result_i[9:2]))
      else $error("left justified layout wrong");
   right_place_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL1]
      eoc_i && !left_justify_select_reg |=> {result_high_byte_reg[1:0], result_low_byte_reg}
         == $past(result_i))
      else $error("right justified layout wrong");
   sign_fill_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL2]
      eoc_i && !left_justify_select_reg |=> result_high_byte_reg[7:2]
         == {6{$past(differential_i) & result_high_byte_reg[1]}})
      else $error("high byte extension wrong");
   inside_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL10]
      !differential_i && ({lt_high_reg, lt_low_reg} > {gt_high_reg, gt_low_reg})
         && word_next >= {lt_high_reg, lt_low_reg} |-> !match)
      else $error("inside window matched at or above less-than limit");
   outside_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL11]
      !differential_i && ({lt_high_reg, lt_low_reg} <= {gt_high_reg, gt_low_reg})
         && word_next > {gt_high_reg, gt_low_reg} |-> match)
      else $error("outside window missed value above greater-than limit");
   signed_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL12]
      differential_i && $signed(word_next) < $signed({lt_high_reg, lt_low_reg})
         && $signed({lt_high_reg, lt_low_reg}) <= $signed({gt_high_reg, gt_low_reg}) |-> match)
      else $error("signed outside compare missed low value");

   // Flag handshake with software
   clear_flag_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL14]
      soft_clear_s |=> !window_match_flag_reg)
      else $error("window flag not cleared by software write");
   set_wins_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL7]
      clash_s |=> flag_up_s)
      else $error("software clear beat a matching conversion");

   // Limit registers take the written byte, the justify select its written bit
   gt_high_wr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL9]
      wr_gt_high |=> gt_high_reg == $past(sfr_wdata_i))
      else $error("greater-than high byte not written");
   gt_low_wr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL9]
      wr_gt_low |=> gt_low_reg == $past(sfr_wdata_i))
      else $error("greater-than low byte not written");
   lt_high_wr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL9]
      wr_lt_high |=> lt_high_reg == $past(sfr_wdata_i))
      else $error("less-than high byte not written");
   lt_low_wr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL9]
      wr_lt_low |=> lt_low_reg == $past(sfr_wdata_i))
      else $error("less-than low byte not written");
   ljst_wr_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL15]
      wr_ctrl |=> left_justify_select_reg == $past(sfr_wdata_i[adc_window_pkg::CTRL_LJST_BIT]))
      else $error("justify select not written");

   // Result bytes only move on a conversion
   result_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL6]
      !eoc_i |=> $stable(result_high_byte_reg) && $stable(result_low_byte_reg))
      else $error("result bytes changed without a conversion");
   left_low_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL3]
      eoc_i && left_justify_select_reg |=> result_low_byte_reg[7:6] == $past(result_i[1:0]))
      else $error("left justified low bits wrong");

   // Read path
   read_idle_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL8]
      !sfr_rd_i |-> sfr_rdata_o == 8'h_00)
      else $error("read data not zero while idle");
   read_flag_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL8]
      sfr_rd_i && sfr_addr_i == adc_window_pkg::ADDR_CONTROL
         |-> sfr_rdata_o[adc_window_pkg::CTRL_WMATCH_BIT] == window_match_flag_reg)
      else $error("window flag not readable");
   read_gt_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i) // [RL9]
      sfr_rd_i && sfr_addr_i == adc_window_pkg::ADDR_GT_HIGH |-> sfr_rdata_o == gt_high_reg)
      else $error("greater-than high byte read wrong");
endmodule // adc_result_window
`default_nettype wire

// ==== bench/conv_source.sv ====
// Behavioural converter model that delivers results to the formatter
`timescale 1ns/10ps
`default_nettype none
module conv_source (
   input wire logic core_clk_i,
   output logic eoc_o,
   output logic [9:0] result_o,
   output logic differential_o
);
   initial begin
      eoc_o = 1'b0;
      result_o = 10'h_000;
      differential_o = 1'b0;
   end
   // Result is only valid with the strobe; inverted afterwards so a late sample shows up
   task automatic convert(input logic [9:0] raw, input logic diff);
      @(posedge core_clk_i);
      #1;
      eoc_o = 1'b1;
      result_o = raw;
      differential_o = diff;
      @(posedge core_clk_i);
      #1;
      eoc_o = 1'b0;
      result_o = ~raw;
   endtask
endmodule // conv_source
`default_nettype wire

// ==== bench/test_adc_result_window.sv ====
// Register-level testbench for the result formatter and window detector
`timescale 1ns/10ps
`default_nettype none
module test_adc_result_window;
   typedef struct packed {logic [15:0] lt; logic [15:0] gt; logic lj; logic d;
      logic [9:0] raw; logic hit;} case_t;
   localparam case_t CASES [14] = '{
      '{16'h_0200, 16'h_0100, 1'h_0, 1'h_0, 10'h_1ff, 1'h_1},
      '{16'h_0200, 16'h_0100, 1'h_0, 1'h_0, 10'h_200, 1'h_0},
      '{16'h_0200, 16'h_0100, 1'h_0, 1'h_0, 10'h_100, 1'h_0},
      '{16'h_0100, 16'h_0200, 1'h_0, 1'h_0, 10'h_0ff, 1'h_1},
      '{16'h_0100, 16'h_0200, 1'h_0, 1'h_0, 10'h_3ff, 1'h_1},
      '{16'h_0100, 16'h_ffff, 1'h_0, 1'h_1, 10'h_000, 1'h_1},
      '{16'h_0100, 16'h_ffff, 1'h_0, 1'h_1, 10'h_3ff, 1'h_0},
      '{16'h_ffff, 16'h_0100, 1'h_0, 1'h_1, 10'h_3fe, 1'h_1},
      '{16'h_8000, 16'h_4000, 1'h_1, 1'h_0, 10'h_1ff, 1'h_1},
      '{16'h_8000, 16'h_4000, 1'h_1, 1'h_0, 10'h_100, 1'h_0},
      '{16'h_0100, 16'h_0100, 1'h_0, 1'h_0, 10'h_101, 1'h_1},
      '{16'h_0100, 16'h_0100, 1'h_0, 1'h_0, 10'h_100, 1'h_0},
      '{16'h_2000, 16'h_ffc0, 1'h_1, 1'h_1, 10'h_200, 1'h_0},
      '{16'h_0000, 16'h_0000, 1'h_0, 1'h_1, 10'h_200, 1'h_1}};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic eoc, diff, wr = 1'b0, rd = 1'b0, flag, ljst;
   logic [9:0] result;
   logic [7:0] addr = 8'h_00, wdata = 8'h_00, rdata;
   int fails = 0;
   int n_checks = 0;
   conv_source src (.core_clk_i(clk), .eoc_o(eoc), .result_o(result), .differential_o(diff));
   adc_result_window uut (.core_clk_i(clk), .resetn_i(resetn), .eoc_i(eoc), .result_i(result),
      .differential_i(diff), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_addr_i(addr),
      .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .window_match_flag_o(flag),
      .left_justify_select_o(ljst));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %0t ns: read 0x%h, expected 0x%h", $time, seen, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      {wr, addr, wdata} = {1'b1, a, d};
      @(posedge clk);
      #1;
      wr = 1'b0;
   endtask
   // Read data is combinational, so it is sampled 5 ns after the strobe rises, with strobe and address held
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      #1;
      {rd, addr} = {1'b1, a};
      #5;
      check(rdata, exp);
      @(posedge clk);
      #1;
      rd = 1'b0;
   endtask
   function automatic logic [15:0] fmt(input logic [9:0] r, input logic lj, input logic d);
      return lj ? {r, 6'h_00} : {{6{d & r[9]}}, r};
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      tally_and_finish;
   end
   initial begin
      logic [15:0] exp;
      repeat (6) @(posedge clk);
      #1;
      resetn = 1'b1;
      rd_reg(adc_window_pkg::ADDR_GT_HIGH, 8'h_ff);
      rd_reg(adc_window_pkg::ADDR_GT_LOW, 8'h_ff);
      rd_reg(adc_window_pkg::ADDR_LT_HIGH, 8'h_00);
      rd_reg(adc_window_pkg::ADDR_LT_LOW, 8'h_00);
      rd_reg(adc_window_pkg::ADDR_CONTROL, 8'h_00);
      rd_reg(8'h_10, 8'h_00);
      $display("test reset values done");
      for (int i = 0; i < 14; i++) begin
         wr_reg(adc_window_pkg::ADDR_CONTROL, {7'h_00, CASES[i].lj});
         wr_reg(adc_window_pkg::ADDR_GT_HIGH, CASES[i].gt[15:8]);
         wr_reg(adc_window_pkg::ADDR_GT_LOW, CASES[i].gt[7:0]);
         wr_reg(adc_window_pkg::ADDR_LT_HIGH, CASES[i].lt[15:8]);
         wr_reg(adc_window_pkg::ADDR_LT_LOW, CASES[i].lt[7:0]);
         src.convert(CASES[i].raw, CASES[i].d);
         exp = fmt(CASES[i].raw, CASES[i].lj, CASES[i].d);
         rd_reg(adc_window_pkg::ADDR_CONTROL, {6'h_00, CASES[i].hit, CASES[i].lj});
         rd_reg(adc_window_pkg::ADDR_RESULT_HIGH, exp[15:8]);
         rd_reg(adc_window_pkg::ADDR_RESULT_LOW, exp[7:0]);
         check({7'h_00, flag}, {7'h_00, CASES[i].hit});
         check({7'h_00, ljst}, {7'h_00, CASES[i].lj});
      end
      $display("test format and window done");
      src.convert(10'h_000, 1'b1);
      rd_reg(adc_window_pkg::ADDR_CONTROL, 8'h_02);
      wr_reg(adc_window_pkg::ADDR_RESULT_LOW, 8'h_55);
      rd_reg(adc_window_pkg::ADDR_RESULT_LOW, 8'h_00);
      wr_reg(adc_window_pkg::ADDR_CONTROL, 8'h_00);
      rd_reg(adc_window_pkg::ADDR_CONTROL, 8'h_00);
      $display("test sticky flag done");
      // Matching conversion and clearing write on the same edge: the set must win
      fork
         src.convert(10'h_200, 1'b1);
         wr_reg(adc_window_pkg::ADDR_CONTROL, 8'h_00);
      join
      rd_reg(adc_window_pkg::ADDR_CONTROL, 8'h_02);
      $display("test set beats clear done");
      tally_and_finish;
   end
endmodule // test_adc_result_window
`default_nettype wire
